// ==== hw/vcub_bridge_end.sv ====
// Board-controller end of the serial bridge, with its receive FIFO and
// the transmit shifter that the target end reuses.
// Assumes link inputs are asynchronous pins and host streams are on sys_clk;
// the receive shifter lives in vcub_target_end.sv.
`timescale 1ns/10ps

module vcub_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input wire logic sys_clk,          // System clock
  input wire logic rst,              // Synchronous reset
  input wire logic [W-1:0] in_data,  // Write data
  input wire logic in_valid,         // Write request
  output logic in_ready,             // Space available
  output logic [W-1:0] out_data,     // Head word
  output logic out_valid,            // Head word present
  input wire logic out_ready         // Head word taken
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);
  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [CW-1:0] cnt;
  } vcub_fifo_st_t;
  vcub_fifo_st_t s, next_s;
  logic [W-1:0] mem [D];
  logic push, pop;

  assign in_ready = s.cnt != CW'(D);
  assign out_valid = s.cnt != '0;
  assign out_data = mem[s.rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    next_s = s;
    if (push) next_s.wr = (s.wr == AW'(D - 1)) ? '0 : s.wr + 1'b1;
    if (pop) next_s.rd = (s.rd == AW'(D - 1)) ? '0 : s.rd + 1'b1;
    next_s.cnt = s.cnt + CW'(push) - CW'(pop);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) s <= '0;
    else s <= next_s;
    if (push) mem[s.wr] <= in_data;
  end
endmodule : vcub_fifo

module vcub_ser_tx (
  input wire logic sys_clk,                       // System clock
  input wire logic rst,                           // Synchronous reset
  input wire logic [vcub_pkg::DIV_W-1:0] div,     // Cycles per bit
  input wire logic go,                            // New character allowed
  input wire logic [vcub_pkg::DATA_W-1:0] data,   // Character to send
  input wire logic valid,                         // Character offered
  output logic ready,                             // Character taken
  output logic line                               // Serial output
);
  typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SHIFT = 2'b10} vcub_tx_state_t;
  typedef struct packed {
    vcub_tx_state_t st;
    logic [vcub_pkg::DIV_W-1:0] cnt;
    logic [3:0] bits;
    logic [vcub_pkg::FRAME_BITS-1:0] shreg;
  } vcub_tx_st_t;
  vcub_tx_st_t s, next_s;

  assign ready = (s.st == TX_IDLE) && go;
  assign line = s.shreg[0];

  always_comb begin
    next_s = s;
    case (s.st)
      TX_IDLE: begin
        if (valid && go) begin
          next_s.shreg = {1'b1, data, 1'b0};
          next_s.cnt = div - 1'b1;
          next_s.bits = '0;
          next_s.st = TX_SHIFT;
        end
      end
      TX_SHIFT: begin
        // Gate is not consulted here, so a started character always finishes
        if (s.cnt == '0) begin
          next_s.shreg = {1'b1, s.shreg[vcub_pkg::FRAME_BITS-1:1]};
          next_s.cnt = div - 1'b1;
          next_s.bits = s.bits + 1'b1;
          if (s.bits == vcub_pkg::TX_LAST_BIT) next_s.st = TX_IDLE;
        end else begin
          next_s.cnt = s.cnt - 1'b1;
        end
      end
      default: next_s.st = TX_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s <= '{st: TX_IDLE, cnt: '0, bits: '0, shreg: '1};
    end else begin
      s <= next_s;
    end
  end
endmodule : vcub_ser_tx

// Overview of operation
// - Reset to 115200 8N1, handshake off.
// - Baud 9600..921600; handshake per line selectable.
// - Target sends on tgt_tx, receives tgt_rx.
// - Clear-to-send deasserted while receive buffer full.
// - Target halts sending while clear-to-send deasserted.
// - Target asserts request-to-send only while its receive buffer is empty.
// - Bridge starts nothing while request-to-send deasserted.
// - Character already shifting always completes.
// - Target takes one more character after deasserting.
// - Disabled mode: clear-to-send undriven, request ignored.
// - Rts mode: drive clear-to-send, ignore request.
// - Cts mode: undriven clear-to-send, honour request.
// - Rtscts mode: drive clear-to-send and honour request.
// - Target must drive request-to-send when honoured.
// - Data passes only while enable active.
// - Socket has priority; USB idle while connected.
// - Four lines plus one enable.
module vcub_bridge_end (
  input wire logic sys_clk,                              // System clock, 20 MHz
  input wire logic rst,                                  // Synchronous reset, active high
  vcub_link_if.bridge link,                              // Link to target
  input wire logic cfg_load,                             // Load new configuration
  input wire logic [vcub_pkg::DIV_W-1:0] cfg_div,        // Cycles per bit to load
  input wire logic [1:0] cfg_hs,                         // Handshake mode to load
  output logic [vcub_pkg::DIV_W-1:0] cur_div,            // Active cycles per bit
  output logic [1:0] cur_hs,                             // Active handshake mode
  input wire logic sock_conn,                            // Socket connected
  input wire logic [vcub_pkg::DATA_W-1:0] usb_tx_data,   // USB byte to target
  input wire logic usb_tx_valid,                         // USB byte offered
  output logic usb_tx_ready,                             // USB byte taken
  output logic [vcub_pkg::DATA_W-1:0] usb_rx_data,       // Byte from target to USB
  output logic usb_rx_valid,                             // Byte for USB present
  input wire logic usb_rx_ready,                         // USB takes byte
  input wire logic [vcub_pkg::DATA_W-1:0] sock_tx_data,  // Socket byte to target
  input wire logic sock_tx_valid,                        // Socket byte offered
  output logic sock_tx_ready,                            // Socket byte taken
  output logic [vcub_pkg::DATA_W-1:0] sock_rx_data,      // Byte from target to socket
  output logic sock_rx_valid,                            // Byte for socket present
  input wire logic sock_rx_ready                         // Socket takes byte
);
  typedef struct packed {
    logic [vcub_pkg::DIV_W-1:0] div;
    logic [1:0] hs;
    logic txd_m, txd_s;
    logic rts_m, rts_s;
    logic en_m, en_s;
  } vcub_bridge_st_t;
  vcub_bridge_st_t s, next_s;

  logic tx_go, tx_valid, tx_ready;
  logic [vcub_pkg::DATA_W-1:0] tx_data, rx_data, fifo_data;
  logic rx_valid, fifo_in_ready, fifo_valid, fifo_ready;

  always_comb begin
    next_s = s;
    next_s.txd_m = link.tgt_tx;
    next_s.txd_s = s.txd_m;
    next_s.rts_m = link.rts_n;
    next_s.rts_s = s.rts_m;
    next_s.en_m = link.enable;
    next_s.en_s = s.en_m;
    // Out-of-range rates are refused and the old setting kept
    if (cfg_load && cfg_div >= vcub_pkg::DIV_FASTEST && cfg_div <= vcub_pkg::DIV_SLOWEST) begin
      next_s.div = cfg_div;
      next_s.hs = cfg_hs;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s <= '{div: vcub_pkg::DIV_DEFAULT, hs: vcub_pkg::HS_DEFAULT,
             txd_m: 1'b1, txd_s: 1'b1, rts_m: 1'b1, rts_s: 1'b1, en_m: 1'b0, en_s: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign cur_div = s.div;
  assign cur_hs = s.hs;

  // Host side: one channel at a time, socket first
  assign tx_data = sock_conn ? sock_tx_data : usb_tx_data;
  assign tx_valid = sock_conn ? sock_tx_valid : usb_tx_valid;
  assign sock_tx_ready = sock_conn && tx_ready;
  assign usb_tx_ready = !sock_conn && tx_ready;
  assign sock_rx_data = fifo_data;
  assign usb_rx_data = fifo_data;
  assign sock_rx_valid = sock_conn && fifo_valid;
  assign usb_rx_valid = !sock_conn && fifo_valid;
  assign fifo_ready = sock_conn ? sock_rx_ready : usb_rx_ready;

  // Request-to-send only matters in the cts and rtscts modes
  assign tx_go = s.en_s && (!s.hs[vcub_pkg::HS_HONOR_BIT] || !s.rts_s);

  // Clear-to-send is driven only in the rts and rtscts modes
  assign link.cts_n_oe = s.hs[vcub_pkg::HS_DRIVE_BIT];
  assign link.cts_n_o = !fifo_in_ready;

  vcub_ser_tx u_tx (
    .sys_clk(sys_clk),
    .rst(rst),
    .div(s.div),
    .go(tx_go),
    .data(tx_data),
    .valid(tx_valid),
    .ready(tx_ready),
    .line(link.tgt_rx)
  );

  vcub_ser_rx u_rx (
    .sys_clk(sys_clk),
    .rst(rst),
    .div(s.div),
    .en(s.en_s),
    .line(s.txd_s),
    .data(rx_data),
    .valid(rx_valid)
  );

  // A byte arriving while full is lost; with clear-to-send off that is the target's risk
  vcub_fifo #(.W(vcub_pkg::DATA_W), .D(vcub_pkg::FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_data(rx_data),
    .in_valid(rx_valid),
    .in_ready(fifo_in_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready)
  );
endmodule : vcub_bridge_end

// ==== hw/vcub_pkg.sv ====
// Shared constants for the virtual serial bridge and its target end.
// Assumes one 20 MHz system clock shared by both ends.
package vcub_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int DIV_W = 12;
  localparam int BAUD_DEFAULT = 115_200;
  localparam int BAUD_MIN = 9_600;
  localparam int BAUD_MAX = 921_600;
  // Cycles per bit; rounding down keeps the slowest rate legal
  localparam logic [DIV_W-1:0] DIV_DEFAULT = DIV_W'(CLK_HZ / BAUD_DEFAULT);
  localparam logic [DIV_W-1:0] DIV_SLOWEST = DIV_W'(CLK_HZ / BAUD_MIN);
  localparam logic [DIV_W-1:0] DIV_FASTEST = DIV_W'(CLK_HZ / BAUD_MAX);
  localparam int FRAME_BITS = 10;
  localparam logic [3:0] TX_LAST_BIT = 4'(FRAME_BITS - 1);
  localparam logic [2:0] RX_LAST_BIT = 3'(DATA_W - 1);
  // Handshake mode: bit 0 drives clear-to-send, bit 1 honours request-to-send
  localparam int HS_DRIVE_BIT = 0;
  localparam int HS_HONOR_BIT = 1;
  localparam logic [1:0] HS_DISABLED = 2'h0;
  localparam logic [1:0] HS_RTS = 2'h1;
  localparam logic [1:0] HS_CTS = 2'h2;
  localparam logic [1:0] HS_RTSCTS = 2'h3;
  localparam logic [1:0] HS_DEFAULT = HS_DISABLED;
  localparam logic [1:0] TGT_SLOTS = 2'h2;
endpackage : vcub_pkg

// ==== hw/vcub_link_if.sv ====
// Serial link between the bridge and the target: two data lines,
// two handshake lines and one enable.
// Assumes the clear-to-send wire is pulled high when nobody drives it.
`timescale 1ns/10ps
interface vcub_link_if;
  logic tgt_tx;   // Target to bridge serial data
  logic tgt_rx;   // Bridge to target serial data
  logic cts_n_o;  // Clear-to-send value from bridge
  logic cts_n_oe; // Bridge drives clear-to-send
  logic cts_n;    // Resolved clear-to-send, low = go
  logic rts_n;    // Request-to-send from target, low = ready
  logic enable;   // Interface enable from target, high = on

  assign cts_n = cts_n_oe ? cts_n_o : 1'b1;

  modport bridge (input tgt_tx, input rts_n, input enable, output tgt_rx, output cts_n_o, output cts_n_oe);
  modport target (output tgt_tx, output rts_n, output enable, input tgt_rx, input cts_n);
endinterface : vcub_link_if

// ==== hw/vcub_target_end.sv ====
// Target end of the serial bridge: a UART with optional handshake and a
// two-slot receive buffer, plus the receive shifter that both ends share.
// Assumes vcub_bridge_end.sv supplies the transmit shifter.
`timescale 1ns/10ps
module vcub_target_end (
  input wire logic sys_clk,                          // System clock, 20 MHz
  input wire logic rst,                              // Synchronous reset, active high
  vcub_link_if.target link,                          // Link to bridge
  input wire logic [vcub_pkg::DIV_W-1:0] div,        // Cycles per bit
  input wire logic hs_en,                            // Honour clear-to-send
  input wire logic port_en,                          // Drive interface enable
  input wire logic [vcub_pkg::DATA_W-1:0] tx_data,   // Byte to bridge
  input wire logic tx_valid,                         // Byte offered
  output logic tx_ready,                             // Byte taken
  output logic [vcub_pkg::DATA_W-1:0] rx_data,       // Byte from bridge
  output logic rx_valid,                             // Byte present
  input wire logic rx_ready                          // Byte taken by user
);
  typedef struct packed {
    logic rxd_m, rxd_s;
    logic cts_m, cts_s;
    logic en;
    logic [1:0] cnt;
    logic [vcub_pkg::DATA_W-1:0] b0, b1;
  } vcub_target_st_t;
  vcub_target_st_t s, next_s;

  logic [vcub_pkg::DATA_W-1:0] in_data;
  logic in_valid, push, pop, tx_go;

  assign pop = rx_ready && s.cnt != '0;
  // Second slot catches the character already in flight when request drops
  assign push = in_valid && (s.cnt != vcub_pkg::TGT_SLOTS || pop);

  always_comb begin
    next_s = s;
    next_s.rxd_m = link.tgt_rx;
    next_s.rxd_s = s.rxd_m;
    next_s.cts_m = link.cts_n;
    next_s.cts_s = s.cts_m;
    next_s.en = port_en;
    case ({push, pop})
      2'b10: begin
        if (s.cnt == '0) next_s.b0 = in_data;
        else next_s.b1 = in_data;
        next_s.cnt = s.cnt + 1'b1;
      end
      2'b01: begin
        next_s.b0 = s.b1;
        next_s.cnt = s.cnt - 1'b1;
      end
      2'b11: begin
        next_s.b0 = (s.cnt == 2'h1) ? in_data : s.b1;
        if (s.cnt != 2'h1) next_s.b1 = in_data;
      end
      default: next_s.cnt = s.cnt;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s <= '{rxd_m: 1'b1, rxd_s: 1'b1, cts_m: 1'b1, cts_s: 1'b1, en: 1'b0, cnt: '0, b0: '0, b1: '0};
    end else begin
      s <= next_s;
    end
  end

  assign rx_data = s.b0;
  assign rx_valid = s.cnt != '0;
  assign link.rts_n = s.cnt != '0;
  assign link.enable = s.en;
  assign tx_go = s.en && (!hs_en || !s.cts_s);

  vcub_ser_tx u_tx (
    .sys_clk(sys_clk),
    .rst(rst),
    .div(div),
    .go(tx_go),
    .data(tx_data),
    .valid(tx_valid),
    .ready(tx_ready),
    .line(link.tgt_tx)
  );

  vcub_ser_rx u_rx (
    .sys_clk(sys_clk),
    .rst(rst),
    .div(div),
    .en(1'b1),
    .line(s.rxd_s),
    .data(in_data),
    .valid(in_valid)
  );
endmodule : vcub_target_end

module vcub_ser_rx (
  input wire logic sys_clk,                       // System clock
  input wire logic rst,                           // Synchronous reset
  input wire logic [vcub_pkg::DIV_W-1:0] div,     // Cycles per bit
  input wire logic en,                            // Start bits accepted
  input wire logic line,                          // Synchronised serial input
  output logic [vcub_pkg::DATA_W-1:0] data,       // Received character
  output logic valid                              // One-cycle receive strobe
);
  typedef enum logic [3:0] {
    RX_IDLE = 4'h1, RX_START = 4'h2, RX_DATA = 4'h4, RX_STOP = 4'h8
  } vcub_rx_state_t;
  typedef struct packed {
    vcub_rx_state_t st;
    logic [vcub_pkg::DIV_W-1:0] cnt;
    logic [2:0] bits;
    logic [vcub_pkg::DATA_W-1:0] shreg;
    logic [vcub_pkg::DATA_W-1:0] data;
    logic valid;
  } vcub_rx_st_t;
  vcub_rx_st_t s, next_s;

  assign data = s.data;
  assign valid = s.valid;

  always_comb begin
    next_s = s;
    next_s.valid = 1'h0;
    case (s.st)
      RX_IDLE: begin
        if (en && !line) begin
          next_s.cnt = div >> 1;
          next_s.st = RX_START;
        end
      end
      RX_START: begin
        // Recheck mid-bit so a glitch is not taken as a start
        if (s.cnt != '0) next_s.cnt = s.cnt - 1'h1;
        else if (line) next_s.st = RX_IDLE;
        else begin
          next_s.cnt = div - 1'h1;
          next_s.bits = '0;
          next_s.st = RX_DATA;
        end
      end
      RX_DATA: begin
        if (s.cnt != '0) next_s.cnt = s.cnt - 1'h1;
        else begin
          next_s.shreg = {line, s.shreg[vcub_pkg::DATA_W-1:1]};
          next_s.cnt = div - 1'h1;
          next_s.bits = s.bits + 1'h1;
          if (s.bits == vcub_pkg::RX_LAST_BIT) next_s.st = RX_STOP;
        end
      end
      RX_STOP: begin
        if (s.cnt != '0) next_s.cnt = s.cnt - 1'h1;
        else begin
          // A low stop bit is a framing error; the character is dropped
          next_s.valid = line;
          next_s.data = line ? s.shreg : s.data;
          next_s.st = RX_IDLE;
        end
      end
      default: next_s.st = RX_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) s <= '{st: RX_IDLE, cnt: '0, bits: '0, shreg: '0, data: '0, valid: 1'h0};
    else s <= next_s;
  end
endmodule : vcub_ser_rx

// ==== verif/vcub_link_chk.sv ====
// Checker for the serial link joining the bridge end and the target end.
// Assumes one system clock with a synchronous active-high reset.
`timescale 1ns/10ps
module vcub_link_chk (
  input logic sys_clk, // System clock
  input logic rst, // Synchronous reset
  input logic tgt_tx, // Target to bridge serial
  input logic tgt_rx, // Bridge to target serial
  input logic cts_n_o, // Bridge clear-to-send value
  input logic cts_n_oe, // Bridge drives clear-to-send
  input logic cts_n, // Resolved clear-to-send
  input logic rts_n, // Target request-to-send
  input logic enable // Interface enable
);
  // Ten bits at the slowest divisor; past this a disabled link must be idle
  localparam int EN_QUIET = 20900;
  logic [15:0] quiet;

  always_ff @(posedge sys_clk) begin
    if (rst || enable) begin
      quiet <= 16'h0000;
    end else if (quiet != 16'hffff) begin
      quiet <= quiet + 16'h0001;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_reset_idle;
    $fell(rst) |-> tgt_rx && tgt_tx && !cts_n_oe && !enable;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("link not idle after reset");
  // Shortest legal bit is 21 cycles
  property p_rx_bit;
    $fell(tgt_rx) |-> !tgt_rx [*8];
  endproperty
  a_rx_bit: assert property (p_rx_bit) else $error("bridge low bit too short");
  property p_tx_bit;
    $rose(tgt_tx) |-> tgt_tx [*8];
  endproperty
  a_tx_bit: assert property (p_tx_bit) else $error("target high bit too short");
  property p_cts_stop;
    $rose(cts_n_o) |-> tgt_tx [*4];
  endproperty
  a_cts_stop: assert property (p_cts_stop) else $error("buffer full outside a stop bit");
  property p_rts_stop;
    $rose(rts_n) |-> tgt_rx [*4];
  endproperty
  a_rts_stop: assert property (p_rts_stop) else $error("request withdrawn outside a stop bit");
  property p_cts_pull;
    !cts_n_oe |-> cts_n;
  endproperty
  a_cts_pull: assert property (p_cts_pull) else $error("undriven clear-to-send not high");
  property p_en_quiet;
    quiet > EN_QUIET |-> tgt_rx && tgt_tx;
  endproperty
  a_en_quiet: assert property (p_en_quiet) else $error("traffic while link disabled");
  property p_en_sync;
    $rose(enable) |-> tgt_rx [*2];
  endproperty
  a_en_sync: assert property (p_en_sync) else $error("start bit too soon after enable");

  c_full: cover property ($rose(cts_n_o));
  c_hold: cover property ($rose(rts_n));
  c_drive: cover property (cts_n_oe && !cts_n);
endmodule : vcub_link_chk

// ==== verif/vcom_uart_flow_bridge_tb.sv ====
// Self-checking bench: bridge end and target end joined by the link.
// Assumes the package, link interface and both ends are compiled first.
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch %s expected %h seen %h", n, e, g); end end
module vcom_uart_flow_bridge_tb;
  logic sys_clk;
  logic rst = 1'h1, cfg_load = 1'h0, sock_conn = 1'h0, hs_en = 1'h0, port_en = 1'h1;
  logic usb_tx_valid = 1'h0, sock_tx_valid = 1'h0, usb_rx_ready = 1'h0, sock_rx_ready = 1'h0;
  logic tx_valid = 1'h0, rx_ready = 1'h0;
  logic [7:0] h_d = 8'h00, tx_data = 8'h00;
  logic [11:0] cfg_div = 12'h000;
  logic [1:0] cfg_hs = 2'h0;
  logic [11:0] cur_div;
  logic [1:0] cur_hs;
  logic usb_tx_ready, sock_tx_ready, usb_rx_valid, sock_rx_valid, tx_ready, rx_valid;
  logic [7:0] usb_rx_data, sock_rx_data, rx_data;
  int dv = vcub_pkg::DIV_DEFAULT;
  int n_tests = 0, n_fail = 0, cyc = 0;

  vcub_link_if link();
  vcub_bridge_end vcub_bridge_end_i (.sys_clk, .rst, .link(link), .cfg_load, .cfg_div, .cfg_hs, .cur_div, .cur_hs,
    .sock_conn, .usb_tx_data(h_d), .usb_tx_valid, .usb_tx_ready, .usb_rx_data, .usb_rx_valid, .usb_rx_ready,
    .sock_tx_data(h_d), .sock_tx_valid, .sock_tx_ready, .sock_rx_data, .sock_rx_valid, .sock_rx_ready);
  vcub_target_end vcub_target_end_i (.sys_clk, .rst, .link(link), .div(12'(dv)), .hs_en, .port_en, .tx_data,
    .tx_valid, .tx_ready, .rx_data, .rx_valid, .rx_ready);
  vcub_link_chk vcub_link_chk_i (.sys_clk, .rst, .tgt_tx(link.tgt_tx), .tgt_rx(link.tgt_rx), .cts_n_o(link.cts_n_o),
    .cts_n_oe(link.cts_n_oe), .cts_n(link.cts_n), .rts_n(link.rts_n), .enable(link.enable));

  initial begin
    sys_clk = 1'h0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic clk(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : clk

  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results

  // Whole run needs about 31000 cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 80000) begin
      n_fail++;
      $display("mismatch cycle limit reached");
      results();
    end
  end

  task automatic cfg(input logic [11:0] d, input logic [1:0] m);
    cfg_div = d;
    cfg_hs = m;
    cfg_load = 1'h1;
    clk(1);
    cfg_load = 1'h0;
    clk(1);
  endtask : cfg

  // Samples one character mid-bit on either serial line
  task automatic frame(input logic tx, input logic [7:0] b);
    logic [9:0] w;
    int i;
    for (i = 0; i < 3000 && (tx ? link.tgt_tx : link.tgt_rx); i++) clk(1);
    clk(dv / 2);
    for (i = 0; i < 10; i++) begin
      w[i] = tx ? link.tgt_tx : link.tgt_rx;
      if (i < 9) clk(dv);
    end
    `CHK("frame", {1'h1, b, 1'h0}, w)
  endtask : frame

  task automatic h2t(input logic [7:0] b, input logic s);
    int i;
    h_d = b;
    sock_tx_valid = s;
    usb_tx_valid = !s;
    for (i = 0; i < 3000 && !(s ? sock_tx_ready : usb_tx_ready); i++) clk(1);
    clk(1);
    sock_tx_valid = 1'h0;
    usb_tx_valid = 1'h0;
    frame(1'h0, b);
  endtask : h2t

  task automatic t2h(input logic [7:0] b);
    int i;
    tx_data = b;
    tx_valid = 1'h1;
    for (i = 0; i < 3000 && !tx_ready; i++) clk(1);
    clk(1);
    tx_valid = 1'h0;
    frame(1'h1, b);
  endtask : t2h

  task automatic rcv(input logic s, input logic [7:0] b);
    int i;
    for (i = 0; i < 3000 && !(s ? sock_rx_valid : usb_rx_valid); i++) clk(1);
    `CHK("host_rx_data", b, s ? sock_rx_data : usb_rx_data)
    sock_rx_ready = s;
    usb_rx_ready = !s;
    clk(1);
    sock_rx_ready = 1'h0;
    usb_rx_ready = 1'h0;
  endtask : rcv

  task automatic pop(input logic [7:0] b);
    int i;
    for (i = 0; i < 3000 && !rx_valid; i++) clk(1);
    `CHK("tgt_rx_data", b, rx_data)
    rx_ready = 1'h1;
    clk(1);
    rx_ready = 1'h0;
  endtask : pop

  task automatic t_cfg;
    `CHK("cur_div", vcub_pkg::DIV_DEFAULT, cur_div)
    `CHK("cur_hs", vcub_pkg::HS_DEFAULT, cur_hs)
    cfg(12'(vcub_pkg::DIV_FASTEST - 1), vcub_pkg::HS_RTSCTS);
    `CHK("cur_div", vcub_pkg::DIV_DEFAULT, cur_div)
    `CHK("cur_hs", vcub_pkg::HS_DEFAULT, cur_hs)
    cfg(12'(vcub_pkg::DIV_SLOWEST + 1), vcub_pkg::HS_RTS);
    `CHK("cur_div", vcub_pkg::DIV_DEFAULT, cur_div)
    cfg(vcub_pkg::DIV_SLOWEST, vcub_pkg::HS_CTS);
    `CHK("cur_div", vcub_pkg::DIV_SLOWEST, cur_div)
    for (int m = 0; m < 4; m++) begin
      cfg(vcub_pkg::DIV_FASTEST, 2'(m));
      `CHK("cur_hs", 2'(m), cur_hs)
      `CHK("cts_n_oe", m[vcub_pkg::HS_DRIVE_BIT], link.cts_n_oe)
      `CHK("cts_n", ~m[vcub_pkg::HS_DRIVE_BIT], link.cts_n)
    end
    dv = vcub_pkg::DIV_FASTEST;
  endtask : t_cfg

  // Second byte is held off only where request-to-send is honoured
  task automatic t_rts;
    for (int m = 0; m < 4; m++) begin
      cfg(12'(dv), 2'(m));
      h2t(8'ha5, 1'h0);
      fork
        h2t(8'h3c, 1'h0);
        begin
          clk(40 * dv);
          `CHK("usb_tx_ready", ~m[vcub_pkg::HS_HONOR_BIT], usb_tx_ready)
          `CHK("rts_n", 1'h1, link.rts_n)
          pop(8'ha5);
        end
      join
      pop(8'h3c);
    end
  endtask : t_rts

  task automatic t_fill;
    int k;
    hs_en = 1'h1;
    cfg(12'(dv), vcub_pkg::HS_RTS);
    for (k = 0; k < vcub_pkg::FIFO_DEPTH; k++) t2h(8'(k * 37 + 1));
    clk(dv);
    `CHK("cts_n", 1'h1, link.cts_n)
    fork
      t2h(8'hee);
      begin
        clk(40 * dv);
        `CHK("tx_ready", 1'h0, tx_ready)
        for (k = 0; k < vcub_pkg::FIFO_DEPTH; k++) rcv(1'h0, 8'(k * 37 + 1));
        rcv(1'h0, 8'hee);
      end
    join
    `CHK("usb_rx_valid", 1'h0, usb_rx_valid)
    `CHK("cts_n", 1'h0, link.cts_n)
  endtask : t_fill

  task automatic t_sock;
    sock_conn = 1'h1;
    clk(2);
    `CHK("usb_tx_ready", 1'h0, usb_tx_ready)
    h2t(8'h69, 1'h1);
    pop(8'h69);
    t2h(8'h96);
    clk(dv);
    `CHK("usb_rx_valid", 1'h0, usb_rx_valid)
    rcv(1'h1, 8'h96);
    sock_conn = 1'h0;
  endtask : t_sock

  task automatic t_en;
    port_en = 1'h0;
    // Enable needs three edges to reach the bridge gate; offering sooner starts a frame
    clk(4);
    h_d = 8'h5a;
    usb_tx_valid = 1'h1;
    clk(20996);
    `CHK("usb_tx_ready", 1'h0, usb_tx_ready)
    `CHK("tx_ready", 1'h0, tx_ready)
    `CHK("rx_valid", 1'h0, rx_valid)
    port_en = 1'h1;
    h2t(8'h5a, 1'h0);
    pop(8'h5a);
  endtask : t_en

  initial begin
    clk(3);
    rst = 1'h0;
    clk(2);
    t_cfg();
    t_rts();
    t_fill();
    t_sock();
    t_en();
    results();
  end
endmodule : vcom_uart_flow_bridge_tb
